// *** logic/stc_cfg.svh ***
// Register map, field positions, reset values and timing counts of the system tick counter.
// Assumes inclusion by bare name from the package and the top module.
`ifndef STC_CFG_SVH
`define STC_CFG_SVH
`define STC_BASE_ADDR     32'he000f000
`define STC_OFS_CTRL      8'h00
`define STC_OFS_STATUS    8'h04
`define STC_OFS_CNT_LO    8'h08
`define STC_OFS_CNT_HI    8'h0c
`define STC_OFS_CMP_LO    8'h10
`define STC_OFS_CMP_HI    8'h14
`define STC_OFS_EV_STAT   8'h18
`define STC_OFS_EV_MASK   8'h1c
`define STC_BIT_SOFT      31
`define STC_BIT_INIT      5
`define STC_BIT_DIR       4
`define STC_BIT_RELOAD    3
`define STC_BIT_SRC       2
`define STC_BIT_IRQ_EN    1
`define STC_BIT_RUN       0
`define STC_BIT_MATCH     0
`define STC_EV_MATCH      0
`define STC_EV_SOFT       1
`define STC_EV_W          2
`define STC_RST_WORD      32'h0000_0000
`define STC_RST_COUNT     64'h0000_0000_0000_0000
`define STC_PRESC_DIV     8
`define STC_PRESC_W       3
`endif

// *** logic/stc_pkg.sv ***
// Types shared by the system tick counter.
// Assumes the constants header is on the include path.
`include "stc_cfg.svh"
package stc_pkg;
  typedef enum logic {
    STC_UP   = 1'b0,
    STC_DOWN = 1'b1
  } stc_dir_t;
  typedef logic [63:0] stc_count_t;
endpackage

// *** logic/stc_top.sv ***
// System tick counter: 64-bit up/down counter with compare, reload and interrupts, APB slave.
// Assumes one 25 MHz clock, asynchronous active-low reset and an APB master on the same clock.
//
// Summary of operation
// - Eight zero-reset registers at offsets 0x00-0x1c.
// - Control bit 31 raises software interrupt while set.
// - Writing one to bit 5 loads counter.
// - Control bit 4 selects down, else up.
// - Bit 3 enables wrap or reload at limit.
// - Bit 2 selects clock, else clock/8.
// - Control bit 1 enables counter interrupt.
// - Control bit 0 runs counter, else holds.
// - Match flag set on limit, write-zero clears.
// - Counter readable and writable as two words.
// - Compare value held in two words.
`timescale 1ns/1ps
`default_nettype none
`include "stc_cfg.svh"
module stc_top
  import stc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  output var  logic              irq_counter,
  output var  logic              irq_soft,
  output var  logic              irq
);

  logic                     soft_irq_trigger_r;
  stc_dir_t                 count_dir_r;
  logic                     auto_reload_enable_r;
  logic                     tick_source_select_r;
  logic                     counter_irq_enable_r;
  logic                     counter_run_enable_r;
  logic                     compare_match_flag_r;
  stc_count_t               count_r;
  stc_count_t               count_nxt;
  stc_count_t               compare_r;
  logic [`STC_PRESC_W-1:0]  presc_r;
  logic [`STC_EV_W-1:0]     ev_status_r;
  logic [`STC_EV_W-1:0]     ev_mask_r;
  logic                     soft_d_r;
  logic                     pready_r;
  logic                     pslverr_r;
  logic [31:0]              prdata_r;
  logic                     irq_counter_r;
  logic                     irq_soft_r;
  logic                     irq_r;
  logic                     wr;
  logic                     setup;
  logic [7:0]               ofs;
  logic                     tick;
  logic                     match;
  logic                     mapped;
  logic [31:0]              rd_data;

  assign ofs   = paddr[7:0];
  assign setup = psel && !penable;
  // An unmapped access answers with an error and must not disturb any register.
  assign wr    = psel && penable && pready_r && pwrite && !pslverr_r;

  always_comb begin
    mapped = (paddr[ADDR_W-1:8] == '0) && (paddr[1:0] == 2'b00);
    rd_data = `STC_RST_WORD;
    unique case (ofs)
      `STC_OFS_CTRL: begin
        rd_data[`STC_BIT_SOFT]   = soft_irq_trigger_r;
        rd_data[`STC_BIT_DIR]    = count_dir_r;
        rd_data[`STC_BIT_RELOAD] = auto_reload_enable_r;
        rd_data[`STC_BIT_SRC]    = tick_source_select_r;
        rd_data[`STC_BIT_IRQ_EN] = counter_irq_enable_r;
        rd_data[`STC_BIT_RUN]    = counter_run_enable_r;
      end
      `STC_OFS_STATUS:  rd_data[`STC_BIT_MATCH] = compare_match_flag_r;
      `STC_OFS_CNT_LO:  rd_data = count_r[31:0];
      `STC_OFS_CNT_HI:  rd_data = count_r[63:32];
      `STC_OFS_CMP_LO:  rd_data = compare_r[31:0];
      `STC_OFS_CMP_HI:  rd_data = compare_r[63:32];
      `STC_OFS_EV_STAT: rd_data[`STC_EV_W-1:0] = ev_status_r;
      `STC_OFS_EV_MASK: rd_data[`STC_EV_W-1:0] = ev_mask_r;
      default:          mapped = 1'b0;
    endcase
  end

  // The answer is prepared in the setup cycle so the access phase completes at once.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `STC_RST_WORD;
    end else begin
      pready_r <= setup;
      if (setup) begin
        pslverr_r <= !mapped;
        prdata_r  <= (pwrite || !mapped) ? `STC_RST_WORD : rd_data;
      end
    end
  end

  // Control register; the load bit is write-only and not stored.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      soft_irq_trigger_r   <= 1'b0;
      count_dir_r          <= STC_UP;
      auto_reload_enable_r <= 1'b0;
      tick_source_select_r <= 1'b0;
      counter_irq_enable_r <= 1'b0;
      counter_run_enable_r <= 1'b0;
    end else if (wr && ofs == `STC_OFS_CTRL) begin
      soft_irq_trigger_r   <= pwdata[`STC_BIT_SOFT];
      count_dir_r          <= stc_dir_t'(pwdata[`STC_BIT_DIR]);
      auto_reload_enable_r <= pwdata[`STC_BIT_RELOAD];
      tick_source_select_r <= pwdata[`STC_BIT_SRC];
      counter_irq_enable_r <= pwdata[`STC_BIT_IRQ_EN];
      counter_run_enable_r <= pwdata[`STC_BIT_RUN];
    end
  end

  // Prescaler gives one tick in eight when the divided source is chosen.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      presc_r <= '0;
    end else if (counter_run_enable_r) begin
      presc_r <= presc_r + `STC_PRESC_W'(1);
    end
  end

  assign tick = counter_run_enable_r &&
                (tick_source_select_r || presc_r == `STC_PRESC_W'(`STC_PRESC_DIV - 1));

  always_comb begin
    count_nxt = count_r;
    match     = 1'b0;
    if (tick) begin
      if (count_dir_r == STC_DOWN) begin
        count_nxt = (auto_reload_enable_r && count_r == '0) ? compare_r : count_r - 64'd1;
        match     = (count_nxt == '0);
      end else begin
        count_nxt = (auto_reload_enable_r && count_r == compare_r) ? '0 : count_r + 64'd1;
        match     = (count_nxt == compare_r);
      end
    end
  end

  // Software writes and the load command take priority over a tick in the same cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= `STC_RST_COUNT;
    end else if (wr && ofs == `STC_OFS_CTRL && pwdata[`STC_BIT_INIT]) begin
      count_r <= pwdata[`STC_BIT_DIR] ? compare_r : '0;
    end else if (wr && ofs == `STC_OFS_CNT_LO) begin
      count_r[31:0] <= pwdata;
    end else if (wr && ofs == `STC_OFS_CNT_HI) begin
      count_r[63:32] <= pwdata;
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compare_r <= `STC_RST_COUNT;
    end else if (wr && ofs == `STC_OFS_CMP_LO) begin
      compare_r[31:0] <= pwdata;
    end else if (wr && ofs == `STC_OFS_CMP_HI) begin
      compare_r[63:32] <= pwdata;
    end
  end

  // The flag clears on a written zero, but a match in the same cycle wins.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compare_match_flag_r <= 1'b0;
    end else if (match) begin
      compare_match_flag_r <= 1'b1;
    end else if (wr && ofs == `STC_OFS_STATUS && !pwdata[`STC_BIT_MATCH]) begin
      compare_match_flag_r <= 1'b0;
    end
  end

  // Sticky event bits, cleared by writing one; a new event wins over the clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ev_status_r <= '0;
      ev_mask_r   <= '0;
      soft_d_r    <= 1'b0;
    end else begin
      soft_d_r <= soft_irq_trigger_r;
      if (wr && ofs == `STC_OFS_EV_MASK) begin
        ev_mask_r <= pwdata[`STC_EV_W-1:0];
      end
      if (wr && ofs == `STC_OFS_EV_STAT) begin
        ev_status_r <= ev_status_r & ~pwdata[`STC_EV_W-1:0];
      end
      if (match) begin
        ev_status_r[`STC_EV_MATCH] <= 1'b1;
      end
      if (soft_irq_trigger_r && !soft_d_r) begin
        ev_status_r[`STC_EV_SOFT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_counter_r <= 1'b0;
      irq_soft_r    <= 1'b0;
      irq_r         <= 1'b0;
    end else begin
      irq_counter_r <= compare_match_flag_r && counter_irq_enable_r;
      irq_soft_r    <= soft_irq_trigger_r;
      irq_r         <= |(ev_status_r & ev_mask_r);
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign irq_counter = irq_counter_r;
  assign irq_soft    = irq_soft_r;
  assign irq         = irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_soft_follows;
    1'b1 |=> irq_soft == $past(soft_irq_trigger_r);
  endproperty
  a_soft_follows: assert property (p_soft_follows) else $error("Soft irq not following bit.");

  property p_init_load;
    wr && ofs == `STC_OFS_CTRL && pwdata[`STC_BIT_INIT] |=>
      count_r == ($past(pwdata[`STC_BIT_DIR]) ? $past(compare_r) : 64'd0);
  endproperty
  a_init_load: assert property (p_init_load) else $error("Load command gave wrong count.");

  property p_count_up;
    tick && count_dir_r == STC_UP && !wr && !(auto_reload_enable_r && count_r == compare_r) |=>
      count_r == $past(count_r) + 64'd1;
  endproperty
  a_count_up: assert property (p_count_up) else $error("Up count did not increment.");

  property p_reload_down;
    tick && count_dir_r == STC_DOWN && auto_reload_enable_r && count_r == 64'd0 && !wr |=>
      count_r == $past(compare_r);
  endproperty
  a_reload_down: assert property (p_reload_down) else $error("Down count did not reload.");

  property p_div_eight;
    tick && !tick_source_select_r ##1 !tick_source_select_r[*7] |-> !$past(tick);
  endproperty
  a_div_eight: assert property (p_div_eight) else $error("Divided tick came too soon.");

  property p_hold_stopped;
    !counter_run_enable_r && !wr |=> count_r == $past(count_r);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("Stopped counter moved.");

  property p_match_flag;
    match |=> compare_match_flag_r;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("Match flag not set.");

  property p_write_one_keeps;
    compare_match_flag_r && wr && ofs == `STC_OFS_STATUS && pwdata[`STC_BIT_MATCH] |=>
      compare_match_flag_r;
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps) else $error("Writing one cleared flag.");

  property p_counter_irq;
    compare_match_flag_r && counter_irq_enable_r |=> irq_counter;
  endproperty
  a_counter_irq: assert property (p_counter_irq) else $error("Counter irq missing.");

  property p_cnt_hi_write;
    wr && ofs == `STC_OFS_CNT_HI |=> count_r[63:32] == $past(pwdata);
  endproperty
  a_cnt_hi_write: assert property (p_cnt_hi_write) else $error("High count word not written.");

  property p_apb_answer;
    setup |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer not one cycle.");

  property p_zero_clears;
    wr && ofs == `STC_OFS_STATUS && !pwdata[`STC_BIT_MATCH] && !match |=> !compare_match_flag_r;
  endproperty
  a_zero_clears: assert property (p_zero_clears) else $error("Writing zero kept flag.");

  property p_cmp_lo_write;
    wr && ofs == `STC_OFS_CMP_LO |=> compare_r[31:0] == $past(pwdata);
  endproperty
  a_cmp_lo_write: assert property (p_cmp_lo_write) else $error("Low compare not written.");

  property p_run_write;
    wr && ofs == `STC_OFS_CTRL |=> counter_run_enable_r == $past(pwdata[`STC_BIT_RUN]);
  endproperty
  a_run_write: assert property (p_run_write) else $error("Run bit not written.");

endmodule // stc_top
`default_nettype wire

// *** verification/stc_top_bench.sv ***
// Self-checking bench for the system tick counter, driving its APB port directly.
// Assumes the constants header on the include path and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "stc_cfg.svh"
`define CHK(nm, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); \
  end \
end
module stc_top_bench;
  import stc_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, irq_counter, irq_soft, irq;
  int          miscompares, comparisons, n;

  stc_top #(.ADDR_W(12)) i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_counter(irq_counter), .irq_soft(irq_soft), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {4'h0, a};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (pready !== 1'b1) begin
      miscompares++;
      summarize();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4));
      `CHK("reset_value", 32'h0, rdat)
    end
    rd(8'h20);
    `CHK("unmapped_err", 1'b1, rerr)
    `CHK("unmapped_data", 32'h0, rdat)
    wr(`STC_OFS_CNT_LO, 32'ha5a5_5a5a);
    wr(`STC_OFS_CNT_HI, 32'h1234_5678);
    wr(`STC_OFS_CMP_LO, 32'hcafe_0001);
    wr(`STC_OFS_CMP_HI, 32'h0bad_f00d);
    rd(`STC_OFS_CNT_LO);
    `CHK("count_low", 32'ha5a5_5a5a, rdat)
    rd(`STC_OFS_CNT_HI);
    `CHK("count_high", 32'h1234_5678, rdat)
    rd(`STC_OFS_CMP_LO);
    `CHK("compare_low", 32'hcafe_0001, rdat)
    rd(`STC_OFS_CMP_HI);
    `CHK("compare_high", 32'h0bad_f00d, rdat)
    wr(`STC_OFS_CTRL, 32'hffff_ffde);
    rd(`STC_OFS_CTRL);
    `CHK("control", 32'h8000_001e, rdat)
    `CHK("irq_soft_on", 1'b1, irq_soft)
    `CHK("irq_masked", 1'b0, irq)
    rd(`STC_OFS_EV_STAT);
    `CHK("event_soft", 32'h2, rdat)
    wr(`STC_OFS_EV_MASK, 32'h2);
    repeat (2) @(negedge clk);
    `CHK("irq_on", 1'b1, irq)
    wr(`STC_OFS_CTRL, 32'h0);
    wr(`STC_OFS_EV_STAT, 32'h2);
    repeat (2) @(negedge clk);
    `CHK("irq_soft_off", 1'b0, irq_soft)
    `CHK("irq_off", 1'b0, irq)
  endtask

  task automatic t_up(input logic [31:0] src, input int lo, input int hi);
    logic [31:0] held;
    wr(`STC_OFS_STATUS, 32'h0);
    wr(`STC_OFS_CNT_LO, 32'h0);
    wr(`STC_OFS_CNT_HI, 32'h0);
    wr(`STC_OFS_CMP_LO, 32'd10);
    wr(`STC_OFS_CMP_HI, 32'h0);
    wr(`STC_OFS_CTRL, 32'h3 | src);
    n = 0;
    while (irq_counter !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    `CHK("match_delay", 1'b1, n >= lo && n <= hi)
    if (n == 200) summarize();
    wr(`STC_OFS_CTRL, src | 32'h2);
    rd(`STC_OFS_CNT_LO);
    held = rdat;
    repeat (30) @(posedge clk);
    rd(`STC_OFS_CNT_LO);
    `CHK("count_held", held, rdat)
    wr(`STC_OFS_STATUS, 32'h1);
    rd(`STC_OFS_STATUS);
    `CHK("flag_kept", 32'h1, rdat)
    `CHK("irq_counter_on", 1'b1, irq_counter)
    rd(`STC_OFS_EV_STAT);
    `CHK("event_match", 32'h1, rdat)
    wr(`STC_OFS_EV_STAT, 32'h1);
    rd(`STC_OFS_EV_STAT);
    `CHK("event_cleared", 32'h0, rdat)
    wr(`STC_OFS_CTRL, src);
    repeat (2) @(negedge clk);
    `CHK("irq_counter_off", 1'b0, irq_counter)
    wr(`STC_OFS_STATUS, 32'h0);
    rd(`STC_OFS_STATUS);
    `CHK("flag_clear", 32'h0, rdat)
  endtask

  task automatic t_reload;
    wr(`STC_OFS_CMP_LO, 32'd3);
    wr(`STC_OFS_CTRL, 32'h2c);
    rd(`STC_OFS_CNT_LO);
    `CHK("init_up", 32'h0, rdat)
    wr(`STC_OFS_CTRL, 32'h0d);
    repeat (40) @(posedge clk);
    wr(`STC_OFS_CTRL, 32'h0c);
    rd(`STC_OFS_CNT_LO);
    `CHK("wrap_up", 1'b1, rdat <= 32'd3)
    rd(`STC_OFS_STATUS);
    `CHK("flag_up", 32'h1, rdat)
    wr(`STC_OFS_STATUS, 32'h0);
    wr(`STC_OFS_CTRL, 32'h3c);
    wr(`STC_OFS_CTRL, 32'h1c);
    rd(`STC_OFS_CNT_LO);
    `CHK("init_down", 32'h3, rdat)
    wr(`STC_OFS_CTRL, 32'h1d);
    repeat (40) @(posedge clk);
    wr(`STC_OFS_CTRL, 32'h1c);
    rd(`STC_OFS_CNT_HI);
    `CHK("reload_down", 32'h0, rdat)
    rd(`STC_OFS_STATUS);
    `CHK("flag_down", 32'h1, rdat)
    wr(`STC_OFS_CTRL, 32'h34);
    wr(`STC_OFS_CTRL, 32'h15);
    repeat (20) @(posedge clk);
    wr(`STC_OFS_CTRL, 32'h14);
    rd(`STC_OFS_CNT_HI);
    `CHK("down_underflow", 32'hffff_ffff, rdat)
  endtask

  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end

  initial begin
    nrst        <= 1'b0;
    psel        <= 1'b0;
    penable     <= 1'b0;
    pwrite      <= 1'b0;
    paddr       <= 12'h000;
    pwdata      <= 32'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_up(32'h4, 8, 14);
    t_up(32'h0, 70, 92);
    t_reload();
    summarize();
  end
endmodule // stc_top_bench
`undef CHK
`default_nettype wire
